//--- bit_sync.v
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk_i,   // Local clock
   input  wire             reset_i, // Synchronous reset
   input  wire [WIDTH-1:0] async_i, // Foreign-domain levels
   output wire [WIDTH-1:0] sync_o   // Two-stage synchronised levels
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   // Two flops; the first is read only by the second
   always @(posedge clk_i) begin
      if (reset_i) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule // bit_sync

`default_nettype wire

//--- lb_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module lb_far_end (
   input  wire logic run_i,      // Frame in progress
   input  wire logic pos_i,      // Positive rail level to send
   input  wire logic neg_i,      // Negative rail level to send
   output logic      line_clk_o, // Line clock, still between frames
   output logic      pos_o,      // Positive rail
   output logic      neg_o       // Negative rail
);
   initial begin
      line_clk_o = 1'b0;
      pos_o = 1'b0;
      neg_o = 1'b0;
   end

   // Rails change on the falling clock; released rails invert
   always begin
      wait (run_i);
      #32 line_clk_o = 1'b1;
      #32 line_clk_o = 1'b0;
      pos_o = run_i ? pos_i : ~pos_o;
      neg_o = run_i ? neg_i : ~neg_o;
   end
endmodule // lb_far_end
`default_nettype wire

//--- lb_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "loopback_router_regs.vh"

module lb_props #(
   parameter NUM_DS2 = 7,
   parameter BUS_W   = 8
) (
   input wire logic               clk_i,            // Clock
   input wire logic               reset_i,          // Reset
   input wire logic               psel_i,           // Select
   input wire logic               penable_i,        // Access
   input wire logic               pwrite_i,         // Direction
   input wire logic [11:0]        paddr_i,          // Address
   input wire logic [31:0]        pwdata_i,         // Write data
   input wire logic               rx_ja_data_i,     // Receive data
   input wire logic               tx_trib_data_i,   // Transmit data
   input wire logic               es_data_i,        // Elastic store
   input wire logic               trib_tx_data_o,   // Toward mux
   input wire logic               framer_rx_data_o, // Framer input
   input wire logic [BUS_W-1:0]   add_src_i,        // Add stream
   input wire logic [BUS_W-1:0]   add_data_o,       // Add bus
   input wire logic [BUS_W-1:0]   sonet_rx_o,       // Receive path
   input wire logic               ds3_tx_pos_i,     // DS3 transmit
   input wire logic               ds3_rx_pos_o,     // DS3 receive
   input wire logic [NUM_DS2-1:0] ds2_demux_i,      // DS2 loops
   input wire logic [NUM_DS2-1:0] ds2_src_i,        // DS2 normal
   input wire logic [NUM_DS2-1:0] ds2_to_ds3_mux_o  // DS2 out
);
   logic [3:0]         t1_ff;
   logic [1:0]         ad_ff;
   logic [4:0]         d3_ff;
   logic [NUM_DS2-1:0] m2_ff;

   // Shadow of the loop controls
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         {t1_ff, ad_ff, d3_ff, m2_ff} <= '0;
      end else if (psel_i && penable_i && pwrite_i) begin
         case (paddr_i)
            `LB_T1E1_CTRL_OFS: t1_ff <= pwdata_i[3:0];
            `LB_ADDROP_CTRL_OFS: ad_ff <= pwdata_i[1:0];
            `LB_DS3_CTRL_OFS: d3_ff <= pwdata_i[4:0];
            `LB_DS2_MASK_OFS: m2_ff <= pwdata_i[NUM_DS2-1:0];
            default: ;
         endcase
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // Add stream looped into the receive path
   sequence ad_diag_on;
      $past(ad_ff[0]);
   endsequence
   sequence rx_takes_add;
      sonet_rx_o == $past(add_src_i);
   endsequence

   a_trib_line_path: assert property (
      $past(t1_ff[0]) |-> trib_tx_data_o == $past(rx_ja_data_i, 3))
      else $error("line loop data wrong");
   a_trib_diag_path: assert property (
      $past(t1_ff[1]) |-> framer_rx_data_o == $past(tx_trib_data_i, 3))
      else $error("diag loop data wrong");
   a_full_payload_path: assert property (
      $past(t1_ff[3] && !t1_ff[0]) |-> trib_tx_data_o == $past(es_data_i))
      else $error("full payload data wrong");
   a_add_diag_feed: assert property (ad_diag_on |-> rx_takes_add)
      else $error("add stream not in receive path");
   a_add_keeps_sending: assert property (
      $past(ad_ff[0] && !ad_ff[1]) |-> add_data_o == $past(add_src_i))
      else $error("add bus stopped");
   a_ds3_diag_feed: assert property (
      $past(d3_ff[0]) |-> ds3_rx_pos_o == $past(ds3_tx_pos_i))
      else $error("DS3 diag data wrong");
   a_ds2_demux_loop: assert property (
      $past(d3_ff[3]) |-> ds2_to_ds3_mux_o ==
         $past((ds2_demux_i & m2_ff) | (ds2_src_i & ~m2_ff)))
      else $error("DS2 loop streams wrong");
   a_loops_off_reset: assert property (
      $fell(reset_i) |-> !trib_tx_data_o && !framer_rx_data_o && !ds3_rx_pos_o
         && add_data_o == '0 && sonet_rx_o == '0 && ds2_to_ds3_mux_o == '0)
      else $error("output active after reset");
endmodule // lb_props

bind multilevel_loopback_router lb_props #(.NUM_DS2(NUM_DS2), .BUS_W(BUS_W)) props_u (.*);
`default_nettype wire

//--- loopback_router_regs.vh
`ifndef LOOPBACK_ROUTER_REGS_VH
`define LOOPBACK_ROUTER_REGS_VH

// Register byte offsets
`define LB_T1E1_CTRL_OFS   12'h000
`define LB_T1E1_CHMASK_OFS 12'h004
`define LB_ADDROP_CTRL_OFS 12'h008
`define LB_DS3_CTRL_OFS    12'h00C
`define LB_DS2_MASK_OFS    12'h010
`define LB_DS1_MASK_OFS    12'h014
`define LB_STATUS_OFS      12'h018

// Tributary loop control fields
`define LB_T1E1_LINE_BIT   0
`define LB_T1E1_DIAG_BIT   1
`define LB_T1E1_CHAN_BIT   2
`define LB_T1E1_FULL_BIT   3
`define LB_T1E1_SEL_LSB    8
`define LB_T1E1_SEL_MSB    12

// Add/drop bus loop control fields
`define LB_AD_DIAG_BIT     0
`define LB_AD_LINE_BIT     1
`define LB_AD_ING_LSB      8
`define LB_AD_ING_MSB      11
`define LB_AD_EGR_LSB      12
`define LB_AD_EGR_MSB      15

// DS3 loop control fields
`define LB_DS3_DIAG_BIT    0
`define LB_DS3_LINE_BIT    1
`define LB_DS3_PAY_BIT     2
`define LB_DS3_DS2_BIT     3
`define LB_DS3_DS1_BIT     4

// Status fields
`define LB_ST_MISMATCH_BIT 0
`define LB_ST_FULL_BIT     1
`define LB_ST_EMPTY_BIT    2
`define LB_ST_RXCLK_BIT    3
`define LB_ST_ACTIVE_BIT   4

// Reset values: every loop off
`define LB_CTRL_RST        32'h0000_0000
`define LB_MASK_RST        32'h0000_0000

// Synchroniser depth
`define LB_SYNC_STAGES     2

`endif

//--- multilevel_loopback_router.v
// How it works
// - Tributary line loop sends the jitter-attenuated receive clock and data to the transmit path.
// - Tributary diagnostic loop feeds the framer's own transmit clock and data to its receive input.
// - Per-channel loop sends elastic store data back through the transmitter for chosen slots.
// - Full payload loop returns every channel of the tributary at once.
// - Add/drop diagnostic loop feeds the add stream into the receive path instead of the drop bus.
// - During the add/drop diagnostic loop with the line loop off, the add bus keeps carrying the normal transmit data.
// - Add/drop line loop returns drop data only after both tributary pointer processors.
// - DS3 diagnostic loop routes the transmitted DS3 into the receive path instead of the line.
// - DS3 line loop routes the received DS3 into the transmit path instead of the mux output.
// - DS3 payload loop returns payload only, with locally regenerated framing overhead.
// - DS2 demux loop feeds the demultiplexed DS2 streams selected by the DS2 mask back into the DS3 mux.
// - DS1 demux loop feeds the demultiplexed DS1 streams selected by the DS1 mask back into their DS2 muxes.
`timescale 1ns/1ps
`default_nettype none
`include "loopback_router_regs.vh"

module multilevel_loopback_router #(
   parameter NUM_DS2 = 7,
   parameter NUM_DS1 = 28,
   parameter BUS_W   = 8,
   parameter FIFO_D  = 4
) (
   input  wire               clk_i,         // 200 MHz clock
   input  wire               reset_i,       // Synchronous reset, active high
   // APB slave
   input  wire               psel_i,        // Select
   input  wire               penable_i,     // Access phase
   input  wire               pwrite_i,      // Write direction
   input  wire [11:0]        paddr_i,       // Byte address
   input  wire [31:0]        pwdata_i,      // Write data
   output wire               pready_o,      // Always ready
   output reg  [31:0]        prdata_o,      // Read data
   output wire               pslverr_o,     // Unmapped access
   // Tributary framer streams (foreign clocks)
   input  wire               rx_ja_clk_i,   // Jitter-attenuated receive clock
   input  wire               rx_ja_data_i,  // Jitter-attenuated receive data
   input  wire               tx_trib_clk_i, // Framer transmit clock
   input  wire               tx_trib_data_i,// Framer transmit data
   input  wire [4:0]         trib_slot_i,   // Current timeslot
   input  wire               es_data_i,     // Elastic store output
   output wire [4:0]         framer_sel_o,  // Framer that the loops apply to
   output reg                trib_tx_clk_o, // Clock toward DS3 mux or mapper
   output reg                trib_tx_data_o,// Data toward DS3 mux or mapper
   output reg                framer_rx_clk_o,// Framer receive clock input
   output reg                framer_rx_data_o,// Framer receive data input
   // Add/drop bus
   input  wire [BUS_W-1:0]   drop_data_i,   // Drop bus data (pins)
   input  wire [BUS_W-1:0]   add_src_i,     // Transmit add stream, local logic
   input  wire [BUS_W-1:0]   egr_tpp_data_i,// Egress pointer processor output
   input  wire               egr_tpp_vld_i, // Egress processor output valid
   output wire               egr_tpp_rdy_o, // Loop buffer has room
   input  wire               add_slot_i,    // Add bus takes a byte this cycle
   output reg  [BUS_W-1:0]   add_data_o,    // Add bus data
   output reg  [BUS_W-1:0]   sonet_rx_o,    // Into receive path / ingress processor
   output wire [3:0]         ing_tpp_sel_o, // Ingress tributary_pointer_processor container
   output wire [3:0]         egr_tpp_sel_o, // Egress tributary_pointer_processor container
   // DS3 line and framer
   input  wire               rx_line_clk_i, // DS3 receive line clock (pin)
   input  wire               rx_line_data_positive_i,       // Receive positive rail
   input  wire               rx_line_negative_or_violation_i,// Receive negative rail
   input  wire               ds3_tx_pos_i,  // Transmit DS3 from framer
   input  wire               ds3_tx_neg_i,  // Transmit negative rail
   input  wire               ds3_oh_slot_i, // Overhead bit position
   input  wire               ds3_oh_bit_i,  // Regenerated overhead bit
   output reg                ds3_rx_pos_o,  // Into DS3 receive path
   output reg                ds3_rx_neg_o,  // Into DS3 receive negative rail
   output reg                ds3_line_pos_o,// DS3 transmit line positive
   output reg                ds3_line_neg_o,// DS3 transmit line negative
   // Mux tributaries
   input  wire [NUM_DS2-1:0] ds2_demux_i,   // Demultiplexed DS2 streams
   input  wire [NUM_DS2-1:0] ds2_src_i,     // Normal DS2 streams
   output reg  [NUM_DS2-1:0] ds2_to_ds3_mux_o,// Into ds2_to_ds3_mux
   input  wire [NUM_DS1-1:0] ds1_demux_i,   // Demultiplexed DS1 streams
   input  wire [NUM_DS1-1:0] ds1_src_i,     // Normal DS1 streams
   output reg  [NUM_DS1-1:0] ds1_to_ds2_mux_o // Into ds1_to_ds2_mux
);

   localparam SYNC_W = 7 + BUS_W;

   reg  [31:0]        t1_ctrl_ff;
   reg  [31:0]        chmask_ff;
   reg  [31:0]        ad_ctrl_ff;
   reg  [31:0]        ds3_ctrl_ff;
   reg  [NUM_DS2-1:0] ds2_mask_ff;
   reg  [NUM_DS1-1:0] ds1_mask_ff;
   reg                rxclk_d_ff;
   reg                rx_pos_cap_ff;
   reg                rx_neg_cap_ff;
   reg  [31:0]        nxt_prdata;
   reg                hit;
   wire [SYNC_W-1:0]  sync_bus;
   wire               s_rx_ja_clk;
   wire               s_rx_ja_data;
   wire               s_tx_clk;
   wire               s_tx_data;
   wire               s_rxl_clk;
   wire [BUS_W-1:0]   s_drop;
   wire               wr_en;
   wire               tpp_match;
   wire               line_lb;
   wire               fifo_in_vld;
   wire               fifo_out_vld;
   wire [BUS_W-1:0]   fifo_dat;
   wire               fifo_full;
   wire               fifo_empty;
   wire               slot_looped;
   wire               any_active;
   wire               rxl_rise;
   reg                s_rxl_pos_ff;
   reg                s_rxl_neg_ff;
   wire [1:0]         rails_sync;

   // Pin inputs through two flops
   bit_sync #(
      .WIDTH (SYNC_W)
   ) u_sync_pins (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i ({rx_ja_clk_i, rx_ja_data_i, tx_trib_clk_i, tx_trib_data_i, rx_line_clk_i,
                 rx_line_data_positive_i, rx_line_negative_or_violation_i, drop_data_i}),
      .sync_o  (sync_bus)
   );

   assign {s_rx_ja_clk, s_rx_ja_data, s_tx_clk, s_tx_data, s_rxl_clk, rails_sync,
           s_drop} = sync_bus;

   // APB decode, zero wait states
   assign pready_o  = 1'b1;
   assign wr_en     = psel_i & penable_i & pwrite_i;
   assign pslverr_o = psel_i & penable_i & ~hit;

   // Address hit and read mux
   always @* begin
      hit        = 1'b1;
      nxt_prdata = 32'h0000_0000;
      case (paddr_i)
         `LB_T1E1_CTRL_OFS:   nxt_prdata = t1_ctrl_ff;
         `LB_T1E1_CHMASK_OFS: nxt_prdata = chmask_ff;
         `LB_ADDROP_CTRL_OFS: nxt_prdata = ad_ctrl_ff;
         `LB_DS3_CTRL_OFS:    nxt_prdata = ds3_ctrl_ff;
         `LB_DS2_MASK_OFS:    nxt_prdata[NUM_DS2-1:0] = ds2_mask_ff;
         `LB_DS1_MASK_OFS:    nxt_prdata[NUM_DS1-1:0] = ds1_mask_ff;
         `LB_STATUS_OFS: begin
            nxt_prdata[`LB_ST_MISMATCH_BIT] = ~tpp_match;
            nxt_prdata[`LB_ST_FULL_BIT]     = fifo_full;
            nxt_prdata[`LB_ST_EMPTY_BIT]    = fifo_empty;
            nxt_prdata[`LB_ST_RXCLK_BIT]    = s_rxl_clk;
            nxt_prdata[`LB_ST_ACTIVE_BIT]   = any_active;
         end
         default:             hit = 1'b0;
      endcase
   end

   // Control registers; read data registered during setup
   always @(posedge clk_i) begin
      if (reset_i) begin
         t1_ctrl_ff  <= `LB_CTRL_RST;
         chmask_ff   <= `LB_MASK_RST;
         ad_ctrl_ff  <= `LB_CTRL_RST;
         ds3_ctrl_ff <= `LB_CTRL_RST;
         ds2_mask_ff <= {NUM_DS2{1'b0}};
         ds1_mask_ff <= {NUM_DS1{1'b0}};
         prdata_o    <= 32'h0000_0000;
      end else begin
         if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_o <= nxt_prdata;
         end
         if (wr_en) begin
            case (paddr_i)
               `LB_T1E1_CTRL_OFS:   t1_ctrl_ff  <= pwdata_i;
               `LB_T1E1_CHMASK_OFS: chmask_ff   <= pwdata_i;
               `LB_ADDROP_CTRL_OFS: ad_ctrl_ff  <= pwdata_i;
               `LB_DS3_CTRL_OFS:    ds3_ctrl_ff <= pwdata_i;
               `LB_DS2_MASK_OFS:    ds2_mask_ff <= pwdata_i[NUM_DS2-1:0];
               `LB_DS1_MASK_OFS:    ds1_mask_ff <= pwdata_i[NUM_DS1-1:0];
               default:             ;
            endcase
         end
      end
   end

   assign framer_sel_o  = t1_ctrl_ff[`LB_T1E1_SEL_MSB:`LB_T1E1_SEL_LSB];
   assign ing_tpp_sel_o = ad_ctrl_ff[`LB_AD_ING_MSB:`LB_AD_ING_LSB];
   assign egr_tpp_sel_o = ad_ctrl_ff[`LB_AD_EGR_MSB:`LB_AD_EGR_LSB];
   assign any_active    = (|t1_ctrl_ff[`LB_T1E1_FULL_BIT:0]) | (|ad_ctrl_ff[1:0])
                        | (|ds3_ctrl_ff[`LB_DS3_DS1_BIT:0]);

   assign slot_looped = t1_ctrl_ff[`LB_T1E1_FULL_BIT]
                      | (t1_ctrl_ff[`LB_T1E1_CHAN_BIT] & chmask_ff[trib_slot_i]);

   // Tributary loops
   always @(posedge clk_i) begin
      if (reset_i) begin
         trib_tx_clk_o    <= 1'b0;
         trib_tx_data_o   <= 1'b0;
         framer_rx_clk_o  <= 1'b0;
         framer_rx_data_o <= 1'b0;
      end else begin
         if (t1_ctrl_ff[`LB_T1E1_LINE_BIT]) begin
            trib_tx_clk_o  <= s_rx_ja_clk;
            trib_tx_data_o <= s_rx_ja_data;
         end else if (slot_looped) begin
            trib_tx_clk_o  <= s_tx_clk;
            trib_tx_data_o <= es_data_i;
         end else begin
            trib_tx_clk_o  <= s_tx_clk;
            trib_tx_data_o <= s_tx_data;
         end
         if (t1_ctrl_ff[`LB_T1E1_DIAG_BIT]) begin
            framer_rx_clk_o  <= s_tx_clk;
            framer_rx_data_o <= s_tx_data;
         end else begin
            framer_rx_clk_o  <= s_rx_ja_clk;
            framer_rx_data_o <= s_rx_ja_data;
         end
      end
   end

   // containers must match for loop data
   assign tpp_match   = (ing_tpp_sel_o == egr_tpp_sel_o);
   assign line_lb     = ad_ctrl_ff[`LB_AD_LINE_BIT] & tpp_match;
   assign fifo_in_vld = egr_tpp_vld_i & line_lb;

   stream_fifo #(
      .WIDTH (BUS_W),
      .DEPTH (FIFO_D),
      .AW    (2)
   ) u_loop_fifo (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .in_vld_i  (fifo_in_vld),
      .in_rdy_o  (egr_tpp_rdy_o),
      .in_dat_i  (egr_tpp_data_i),
      .out_vld_o (fifo_out_vld),
      .out_rdy_i (add_slot_i & line_lb),
      .out_dat_o (fifo_dat),
      .full_o    (fifo_full),
      .empty_o   (fifo_empty)
   );

   // Add/drop bus loops
   always @(posedge clk_i) begin
      if (reset_i) begin
         add_data_o <= {BUS_W{1'b0}};
         sonet_rx_o <= {BUS_W{1'b0}};
      end else begin
         sonet_rx_o <= ad_ctrl_ff[`LB_AD_DIAG_BIT] ? add_src_i : s_drop;
         if (ad_ctrl_ff[`LB_AD_LINE_BIT]) begin
            if (add_slot_i & fifo_out_vld) begin
               add_data_o <= fifo_dat;
            end else if (~line_lb) begin
               add_data_o <= {BUS_W{1'b0}};
            end
         end else begin
            add_data_o <= add_src_i;
         end
      end
   end

   // DS3 receive rails captured on line clock rise
   assign rxl_rise = s_rxl_clk & ~rxclk_d_ff;
   always @(posedge clk_i) begin
      if (reset_i) begin
         rxclk_d_ff    <= 1'b0;
         s_rxl_pos_ff  <= 1'b0;
         s_rxl_neg_ff  <= 1'b0;
         rx_pos_cap_ff <= 1'b0;
         rx_neg_cap_ff <= 1'b0;
      end else begin
         rxclk_d_ff   <= s_rxl_clk;
         s_rxl_pos_ff <= rails_sync[1];
         s_rxl_neg_ff <= rails_sync[0];
         if (rxl_rise) begin
            rx_pos_cap_ff <= s_rxl_pos_ff;
            rx_neg_cap_ff <= s_rxl_neg_ff;
         end
      end
   end

   // DS3 and mux loops
   always @(posedge clk_i) begin
      if (reset_i) begin
         ds3_rx_pos_o     <= 1'b0;
         ds3_rx_neg_o     <= 1'b0;
         ds3_line_pos_o   <= 1'b0;
         ds3_line_neg_o   <= 1'b0;
         ds2_to_ds3_mux_o <= {NUM_DS2{1'b0}};
         ds1_to_ds2_mux_o <= {NUM_DS1{1'b0}};
      end else begin
         if (ds3_ctrl_ff[`LB_DS3_DIAG_BIT]) begin
            ds3_rx_pos_o <= ds3_tx_pos_i;
            ds3_rx_neg_o <= ds3_tx_neg_i;
         end else begin
            ds3_rx_pos_o <= rx_pos_cap_ff;
            ds3_rx_neg_o <= rx_neg_cap_ff;
         end
         if (ds3_ctrl_ff[`LB_DS3_LINE_BIT]) begin
            ds3_line_pos_o <= rx_pos_cap_ff;
            ds3_line_neg_o <= rx_neg_cap_ff;
         end else if (ds3_ctrl_ff[`LB_DS3_PAY_BIT]) begin
            ds3_line_pos_o <= ds3_oh_slot_i ? ds3_oh_bit_i : rx_pos_cap_ff;
            ds3_line_neg_o <= 1'b0;
         end else begin
            ds3_line_pos_o <= ds3_tx_pos_i;
            ds3_line_neg_o <= ds3_tx_neg_i;
         end
         ds2_to_ds3_mux_o <= ds3_ctrl_ff[`LB_DS3_DS2_BIT] ?
                             ((ds2_demux_i & ds2_mask_ff) | (ds2_src_i & ~ds2_mask_ff)) :
                             ds2_src_i;
         ds1_to_ds2_mux_o <= ds3_ctrl_ff[`LB_DS3_DS1_BIT] ?
                             ((ds1_demux_i & ds1_mask_ff) | (ds1_src_i & ~ds1_mask_ff)) :
                             ds1_src_i;
      end
   end

endmodule // multilevel_loopback_router

`default_nettype wire

//--- multilevel_loopback_router_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "loopback_router_regs.vh"

module multilevel_loopback_router_bench;
   logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err_q;
   logic        rx_ja_clk_i, rx_ja_data_i, tx_trib_clk_i, tx_trib_data_i, es_data_i;
   logic        trib_tx_clk_o, trib_tx_data_o, framer_rx_clk_o, framer_rx_data_o;
   logic        egr_tpp_vld_i, egr_tpp_rdy_o, add_slot_i, run_q, pos_q, neg_q;
   logic        rx_line_clk_i, rx_line_data_positive_i, rx_line_negative_or_violation_i;
   logic        ds3_tx_pos_i, ds3_tx_neg_i, ds3_oh_slot_i, ds3_oh_bit_i;
   logic        ds3_rx_pos_o, ds3_rx_neg_o, ds3_line_pos_o, ds3_line_neg_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd_q;
   logic [4:0]  trib_slot_i, framer_sel_o;
   logic [7:0]  drop_data_i, add_src_i, egr_tpp_data_i, add_data_o, sonet_rx_o;
   logic [3:0]  ing_tpp_sel_o, egr_tpp_sel_o;
   logic [6:0]  ds2_demux_i, ds2_src_i, ds2_to_ds3_mux_o;
   logic [27:0] ds1_demux_i, ds1_src_i, ds1_to_ds2_mux_o;
   int          mismatches, compares;

   multilevel_loopback_router dut_u (.*);

   lb_far_end far_u (.run_i(run_q), .pos_i(pos_q), .neg_i(neg_q),
      .line_clk_o(rx_line_clk_i), .pos_o(rx_line_data_positive_i),
      .neg_o(rx_line_negative_or_violation_i));

   // Clock at 200 MHz
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // One bounded APB transfer
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rd_q = prdata_o;
      err_q = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   task automatic sc_regs();
      wt(1);
      check({trib_tx_data_o, add_data_o, sonet_rx_o, ds2_to_ds3_mux_o}, 0);
      apb(1'b0, `LB_DS3_CTRL_OFS, 0);
      check(rd_q, `LB_CTRL_RST);
      apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
      check(err_q, 1);
      apb(1'b1, `LB_STATUS_OFS, 32'hFFFF_FFFF);
      apb(1'b0, `LB_STATUS_OFS, 0);
      check(rd_q, 32'h4);
   endtask

   task automatic sc_trib();
      apb(1'b1, `LB_T1E1_CTRL_OFS, 32'h1F01);
      {rx_ja_clk_i, rx_ja_data_i} <= 2'b11;
      wt(5);
      check({framer_sel_o, trib_tx_clk_o, trib_tx_data_o}, 7'h7F);
      apb(1'b1, `LB_T1E1_CTRL_OFS, 32'h2);
      {tx_trib_clk_i, tx_trib_data_i} <= 2'b11;
      {rx_ja_clk_i, rx_ja_data_i} <= 2'b00;
      wt(5);
      check({framer_rx_clk_o, framer_rx_data_o}, 2'b11);
      apb(1'b1, `LB_T1E1_CHMASK_OFS, 32'h20);
      apb(1'b1, `LB_T1E1_CTRL_OFS, 32'h4);
      tx_trib_data_i <= 1'b0;
      es_data_i <= 1'b1;
      trib_slot_i <= 5'h05;
      wt(5);
      check(trib_tx_data_o, 1);
      trib_slot_i <= 5'h06;
      wt(5);
      check(trib_tx_data_o, 0);
      apb(1'b1, `LB_T1E1_CTRL_OFS, 32'h8);
      wt(5);
      check(trib_tx_data_o, 1);
   endtask

   task automatic sc_adddrop();
      apb(1'b1, `LB_ADDROP_CTRL_OFS, 32'h1);
      add_src_i <= 8'hA5;
      drop_data_i <= 8'h3C;
      wt(3);
      check(sonet_rx_o, 8'hA5);
      check(add_data_o, 8'hA5);
      apb(1'b1, `LB_ADDROP_CTRL_OFS, 32'h5502);
      egr_tpp_vld_i <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         egr_tpp_data_i <= 8'h10 + i[7:0];
         wt(1);
      end
      egr_tpp_vld_i <= 1'b0;
      check({ing_tpp_sel_o, egr_tpp_sel_o, egr_tpp_rdy_o}, 9'h0AA);
      add_slot_i <= 1'b1;
      wt(1);
      for (int i = 0; i < 5; i++) begin
         wt(1);
         check(add_data_o, (i < 4) ? 8'h10 + i : 8'h13);
      end
      add_slot_i <= 1'b0;
      check(egr_tpp_rdy_o, 1);
      apb(1'b1, `LB_ADDROP_CTRL_OFS, 32'h6502);
      egr_tpp_vld_i <= 1'b1;
      add_slot_i <= 1'b1;
      wt(4);
      check(add_data_o, 0);
      egr_tpp_vld_i <= 1'b0;
      add_slot_i <= 1'b0;
   endtask

   task automatic sc_ds3();
      apb(1'b1, `LB_DS3_CTRL_OFS, 32'h1);
      ds3_tx_pos_i <= 1'b1;
      wt(2);
      check({ds3_rx_pos_o, ds3_rx_neg_o}, 2'b10);
      ds3_tx_pos_i <= 1'b0;
      apb(1'b1, `LB_DS3_CTRL_OFS, 32'h2);
      run_q <= 1'b1;
      pos_q <= 1'b1;
      wt(60);
      check({ds3_line_pos_o, ds3_line_neg_o}, 2'b10);
      pos_q <= 1'b0;
      neg_q <= 1'b1;
      wt(60);
      check({ds3_line_pos_o, ds3_line_neg_o}, 2'b01);
      apb(1'b1, `LB_DS3_CTRL_OFS, 32'h4);
      ds3_oh_slot_i <= 1'b1;
      ds3_oh_bit_i <= 1'b1;
      wt(3);
      check({ds3_line_pos_o, ds3_line_neg_o}, 2'b10);
      ds3_oh_slot_i <= 1'b0;
      wt(3);
      check({ds3_line_pos_o, ds3_line_neg_o}, 2'b00);
      run_q <= 1'b0;
   endtask

   task automatic sc_mux();
      ds2_demux_i <= 7'h7F;
      ds1_demux_i <= 28'hFFFFFFF;
      apb(1'b1, `LB_DS2_MASK_OFS, 32'h55);
      apb(1'b1, `LB_DS1_MASK_OFS, 32'h0F0F_0F0F);
      apb(1'b1, `LB_DS3_CTRL_OFS, 32'h18);
      wt(2);
      check(ds2_to_ds3_mux_o, 7'h55);
      check(ds1_to_ds2_mux_o, 28'hF0F0F0F);
   endtask

   // Main sequence
   initial begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, rx_ja_clk_i, rx_ja_data_i,
         tx_trib_clk_i, tx_trib_data_i, es_data_i, trib_slot_i, drop_data_i, add_src_i,
         egr_tpp_data_i, egr_tpp_vld_i, add_slot_i, ds3_tx_pos_i, ds3_tx_neg_i,
         ds3_oh_slot_i, ds3_oh_bit_i, ds2_demux_i, ds2_src_i, ds1_demux_i, ds1_src_i,
         run_q, pos_q, neg_q, mismatches, compares} = '0;
      reset_i = 1'b1;
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      sc_regs();
      sc_trib();
      sc_adddrop();
      sc_ds3();
      sc_mux();
      tally_and_finish();
   end
endmodule // multilevel_loopback_router_bench
`default_nettype wire

//--- stream_fifo.v
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk_i,    // Clock
   input  wire             reset_i,  // Synchronous reset
   input  wire             in_vld_i, // Write request
   output wire             in_rdy_o, // Space available
   input  wire [WIDTH-1:0] in_dat_i, // Write data
   output wire             out_vld_o,// Data available
   input  wire             out_rdy_i,// Drain accepts
   output wire [WIDTH-1:0] out_dat_o,// Head data, registered storage
   output wire             full_o,   // No space
   output wire             empty_o   // No data
);

   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      count_ff;
   wire            push;
   wire            pop;

   assign full_o    = (count_ff == DEPTH[AW:0]);
   assign empty_o   = (count_ff == {(AW+1){1'b0}});
   assign in_rdy_o  = ~full_o;
   assign out_vld_o = ~empty_o;
   assign push      = in_vld_i & ~full_o;
   assign pop       = out_rdy_i & ~empty_o;
   assign out_dat_o = mem_ff[rd_ptr_ff];

   // Storage write
   always @(posedge clk_i) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_dat_i;
      end
   end

   // Pointers and occupancy
   always @(posedge clk_i) begin
      if (reset_i) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

endmodule // stream_fifo

`default_nettype wire
